// [rtl/ssa_defs.svh]
// Offsets, field positions, reset values and timing counts of the slope converter timer
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH
`define SSA_OFF_MODE       12'h000
`define SSA_OFF_WIDTH      12'h004
`define SSA_OFF_TRIM       12'h008
`define SSA_OFF_RES1       12'h00C
`define SSA_OFF_RES2       12'h010
`define SSA_OFF_RES3       12'h014
`define SSA_OFF_RESAUX     12'h018
`define SSA_OFF_STATUS     12'h01C
`define SSA_BIT_MUX_LO     0
`define SSA_BIT_MUX_HI     1
`define SSA_BIT_RATE       7
`define SSA_MODE_RST       8'h00
`define SSA_TRIM_RST       3'h0
`define SSA_WIDTH_RST      16'h0064
`define SSA_COUNT_MAX      12'hFFF
`endif

// [rtl/ssa_pkg.sv]
// Types of the slope converter timer
package ssa_pkg;
   typedef struct packed {
      logic [11:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [11:0] araddr;
      logic        arvalid;
      logic        rready;
   } ssa_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } ssa_axi_rsp_t;
   typedef struct packed {
      logic [2:0] trim;
      logic [1:0] aux_sel;
      logic       discharge;
      logic       sync_active;
   } ssa_analog_t;
endpackage

// [rtl/ssa_result_mem.sv]
// Four-word result store with registered read port
`timescale 1ns/1ps
module ssa_result_mem #(
   parameter int WIDTH = 12
) (
   // Clock
   input  wire logic             aclk,
   // Write side, one port per channel
   input  wire logic [3:0]       wr_en,
   input  wire logic [4*WIDTH-1:0] wr_data,
   // Read side
   input  wire logic [1:0]       rd_addr,
   output logic [WIDTH-1:0]      rd_data
);
   logic [WIDTH-1:0] mem_ff [4];
   // Each word holds until its own write; no reset so reads show last capture
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 4; i++) begin
         if (wr_en[i]) begin
            mem_ff[i] <= wr_data[i*WIDTH +: WIDTH];
         end
      end
      rd_data <= mem_ff[rd_addr];
   end
endmodule

// [rtl/ssa_timer.sv]
// Single-slope converter timing, capture and AXI4-Lite registers
`timescale 1ns/1ps
`include "ssa_defs.svh"
module ssa_timer #(
   parameter int CNT_W = 12
) (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Register bus
   input  wire ssa_pkg::ssa_axi_req_t axi_req,
   output ssa_pkg::ssa_axi_rsp_t      axi_rsp,
   // PWM unit and comparators
   input  wire logic                  pwm_cycle_sync_pulse,
   input  wire logic [3:0]            comp_trip,
   // Analog controls
   output ssa_pkg::ssa_analog_t       analog
);
   import ssa_pkg::*;

   initial begin
      if (CNT_W != 12) $error("CNT_W must be 12");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_DISCH, ST_CONV} ssa_phase_t;
   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} ssa_rd_t;

   typedef struct packed {
      ssa_phase_t       phase;
      logic [15:0]      wcnt;
      logic [CNT_W-1:0] count;
      logic             half;
      logic [3:0]       done;
      logic             sync_d;
      logic [7:0]       mode;
      logic [15:0]      width;
      logic [2:0]       trim;
      logic             aw_got;
      logic [11:0]      awaddr;
      logic             w_got;
      logic [31:0]      wdata;
      logic             bvalid;
      logic [1:0]       bresp;
      ssa_rd_t          rd;
      logic [11:0]      araddr;
      logic [31:0]      rdata;
      logic             rvalid;
      logic [1:0]       rresp;
   } ssa_state_t;

   ssa_state_t st_ff;
   ssa_state_t nxt_st;
   logic [3:0]       wr_en;
   logic [4*CNT_W-1:0] wr_data;
   logic [1:0]       mem_addr;
   logic [CNT_W-1:0] mem_q;

   // Result store read and written through its own registered port
   ssa_result_mem #(.WIDTH(CNT_W)) u_mem (
      .aclk    (aclk),
      .wr_en   (wr_en),
      .wr_data (wr_data),
      .rd_addr (mem_addr),
      .rd_data (mem_q)
   );

   // Map byte address to a result word index
   function automatic logic [1:0] res_index(input logic [11:0] a);
      res_index = 2'(a[4:2] - 3'd3);
   endfunction

   function automatic logic is_result(input logic [11:0] a);
      is_result = (a == `SSA_OFF_RES1) || (a == `SSA_OFF_RES2) ||
                  (a == `SSA_OFF_RES3) || (a == `SSA_OFF_RESAUX);
   endfunction

   logic edge_sync;
   logic tick;
   logic at_max;

   always_comb begin
      nxt_st  = st_ff;
      wr_en   = 4'h0;
      wr_data = '0;
      // Idle read port follows the bus, so the word is ready in the wait cycle
      if (st_ff.rd == RD_IDLE) begin
         mem_addr = res_index(axi_req.araddr);
      end else begin
         mem_addr = res_index(st_ff.araddr);
      end
      // Sync rising edge starts a new discharge from idle or conversion; ignored during discharge
      edge_sync = pwm_cycle_sync_pulse && !st_ff.sync_d;
      nxt_st.sync_d = pwm_cycle_sync_pulse;
      // Full rate or every second clock
      tick   = st_ff.mode[`SSA_BIT_RATE] || st_ff.half;
      at_max = (st_ff.count == `SSA_COUNT_MAX);

      unique case (st_ff.phase)
         ST_IDLE: begin
            if (edge_sync) begin
               nxt_st.phase = ST_DISCH;
               nxt_st.wcnt  = st_ff.width;
            end
         end
         ST_DISCH: begin
            // Ramp held at zero for the programmed width
            if (st_ff.wcnt <= 16'h0001) begin
               nxt_st.phase = ST_CONV;
               nxt_st.count = '0;
               nxt_st.half  = 1'b0;
               nxt_st.done  = 4'h0;
            end else begin
               nxt_st.wcnt = 16'(st_ff.wcnt - 16'h0001);
            end
         end
         ST_CONV: begin
            nxt_st.half = !st_ff.half;
            // All four comparators watched on the same count
            for (int i = 0; i < 4; i++) begin
               if (comp_trip[i] && !st_ff.done[i]) begin
                  wr_en[i] = 1'b1;
                  wr_data[i*CNT_W +: CNT_W] = st_ff.count;
                  nxt_st.done[i] = 1'b1;
               end
            end
            if (tick && !at_max) begin
               nxt_st.count = CNT_W'(st_ff.count + 1'b1);
            end
            // Window ends at next sync; untripped channels get overflow code
            if (edge_sync) begin
               for (int i = 0; i < 4; i++) begin
                  if (!st_ff.done[i] && !comp_trip[i]) begin
                     wr_en[i] = 1'b1;
                     wr_data[i*CNT_W +: CNT_W] = `SSA_COUNT_MAX;
                  end
               end
               nxt_st.phase = ST_DISCH;
               nxt_st.wcnt  = st_ff.width;
            end
         end
         // Unused code falls back to idle and waits for the next sync
         default: begin
            nxt_st.phase = ST_IDLE;
         end
      endcase

      // Write address and data accepted in either order
      if (axi_req.awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = axi_req.wdata;
      end
      if (st_ff.aw_got && st_ff.w_got) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = 2'b00;
         unique case (st_ff.awaddr)
            `SSA_OFF_MODE:  nxt_st.mode  = st_ff.wdata[7:0];
            `SSA_OFF_WIDTH: nxt_st.width = st_ff.wdata[15:0];
            `SSA_OFF_TRIM:  nxt_st.trim  = st_ff.wdata[2:0];
            default: begin
               if (!is_result(st_ff.awaddr) && st_ff.awaddr != `SSA_OFF_STATUS) begin
                  nxt_st.bresp = 2'b10;
               end
            end
         endcase
      end
      if (st_ff.bvalid && axi_req.bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Read: one wait cycle lets the result store answer
      unique case (st_ff.rd)
         RD_IDLE: begin
            if (axi_req.arvalid) begin
               nxt_st.araddr = axi_req.araddr;
               nxt_st.rd     = RD_WAIT;
            end
         end
         RD_WAIT: begin
            nxt_st.rd     = RD_RESP;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = 2'b00;
            nxt_st.rdata  = 32'h0000_0000;
            unique case (st_ff.araddr)
               `SSA_OFF_MODE:   nxt_st.rdata = {24'h00_0000, st_ff.mode};
               `SSA_OFF_WIDTH:  nxt_st.rdata = {16'h0000, st_ff.width};
               `SSA_OFF_TRIM:   nxt_st.rdata = {29'h0000_0000, st_ff.trim};
               `SSA_OFF_STATUS: nxt_st.rdata = {26'h000_0000, st_ff.phase, st_ff.done};
               default: begin
                  if (is_result(st_ff.araddr)) begin
                     nxt_st.rdata = {20'h0_0000, mem_q};
                  end else begin
                     nxt_st.rresp = 2'b10;
                  end
               end
            endcase
         end
         RD_RESP: begin
            if (axi_req.rready) begin
               nxt_st.rvalid = 1'b0;
               nxt_st.rd     = RD_IDLE;
            end
         end
         default: nxt_st.rd = RD_IDLE;
      endcase
   end

   // Single state register; synchronous reset to constants
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff       <= '0;
         st_ff.phase <= ST_IDLE;
         st_ff.rd    <= RD_IDLE;
         st_ff.mode  <= `SSA_MODE_RST;
         st_ff.width <= `SSA_WIDTH_RST;
         st_ff.trim  <= `SSA_TRIM_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Bus answers; ready only when the slot is free
   always_comb begin
      axi_rsp.awready = !st_ff.aw_got && !st_ff.bvalid;
      axi_rsp.wready  = !st_ff.w_got && !st_ff.bvalid;
      axi_rsp.bvalid  = st_ff.bvalid;
      axi_rsp.bresp   = st_ff.bresp;
      axi_rsp.arready = (st_ff.rd == RD_IDLE);
      axi_rsp.rvalid  = st_ff.rvalid;
      axi_rsp.rdata   = st_ff.rdata;
      axi_rsp.rresp   = st_ff.rresp;
   end

   // Analog controls straight from registers
   always_comb begin
      analog.trim        = st_ff.trim;
      analog.aux_sel     = {st_ff.mode[`SSA_BIT_MUX_HI], st_ff.mode[`SSA_BIT_MUX_LO]};
      analog.discharge   = (st_ff.phase == ST_DISCH);
      analog.sync_active = (st_ff.phase == ST_CONV);
   end

   // Assertions
   sequence s_sync_edge;
      pwm_cycle_sync_pulse && !st_ff.sync_d;
   endsequence

   a_sync_discharge: assert property (@(posedge aclk) disable iff (!aresetn)
      s_sync_edge |=> (st_ff.phase == ST_DISCH))
      else $error("sync edge did not start discharge");
   a_width_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_sync_edge and (st_ff.phase != ST_DISCH)) |=> (st_ff.wcnt == $past(st_ff.width)))
      else $error("width not loaded");
   a_count_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == ST_DISCH && st_ff.wcnt <= 16'h0001 && !edge_sync) |=> (st_ff.count == '0))
      else $error("count not restarted");
   a_count_cap: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.count == `SSA_COUNT_MAX && st_ff.phase == ST_CONV && !edge_sync) |=> (st_ff.count == `SSA_COUNT_MAX))
      else $error("count passed cap");
   a_slow_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == ST_CONV && !st_ff.mode[`SSA_BIT_RATE] && !st_ff.half && !edge_sync)
      |=> $stable(st_ff.count))
      else $error("slow rate advanced early");
   a_fast_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == ST_CONV && st_ff.mode[`SSA_BIT_RATE] && !at_max && !edge_sync)
      |=> (st_ff.count == CNT_W'($past(st_ff.count) + 1'b1)))
      else $error("fast rate missed tick");
   a_trip_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == ST_CONV && comp_trip[0] && !st_ff.done[0])
      |-> (wr_en[0] && wr_data[CNT_W-1:0] == st_ff.count))
      else $error("trip not captured");
   a_overflow_code: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == ST_CONV && edge_sync && !st_ff.done[3] && !comp_trip[3])
      |-> (wr_en[3] && wr_data[4*CNT_W-1 -: CNT_W] == `SSA_COUNT_MAX))
      else $error("overflow code missing");
   a_one_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.done[1] && !edge_sync && st_ff.phase == ST_CONV) |-> !wr_en[1])
      else $error("second capture in window");
   a_mux_route: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.aw_got && st_ff.w_got && st_ff.awaddr == `SSA_OFF_MODE)
      |=> (analog.aux_sel == $past(st_ff.wdata[1:0])))
      else $error("aux select not taken from mode write");
   a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == ST_DISCH && st_ff.wcnt <= 16'h0001) |=> (st_ff.done == 4'h0))
      else $error("capture flags not cleared for new window");

   // Bus timing as promised to software
   a_resp_next: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.aw_got && st_ff.w_got) |=> st_ff.bvalid)
      else $error("write response late");
   a_read_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_ff.rd == RD_WAIT) |=> (st_ff.rvalid && st_ff.rd == RD_RESP))
      else $error("read answer late");
   a_busy_ready: assert property (@(posedge aclk) disable iff (!aresetn)
      st_ff.bvalid |-> (!axi_rsp.awready && !axi_rsp.wready))
      else $error("write ready while response pending");
endmodule

// [tb/ssa_comp_model.sv]
// Behavioural comparators and ramp capacitor facing the slope timer
`timescale 1ns/1ps
module ssa_comp_model (
   // Clock
   input  wire logic                 aclk,
   // Controls from the timer
   input  wire ssa_pkg::ssa_analog_t analog,
   // Ramp cycles to each crossing, aux is a base
   input  wire logic [63:0]          trip_at,
   // Comparator outputs
   output logic [3:0]                comp_trip
);
   import ssa_pkg::*;
   logic [15:0] ramp_ff = 16'h0000;
   // Ramp held at zero while discharged, saturates so it never wraps
   always_ff @(posedge aclk) begin
      if (analog.discharge) begin
         ramp_ff <= 16'h0000;
      end else if (ramp_ff != 16'hFFFF) begin
         ramp_ff <= ramp_ff + 16'h0001;
      end
   end
   // One comparator per channel, aux crossing moves later per select code
   // Trim modelled on the aux path only: each step up crosses 40 cycles sooner
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         comp_trip[i] = ramp_ff >= trip_at[16*i +: 16];
      end
      comp_trip[3] = ramp_ff >= trip_at[63:48] + 16'(10 * analog.aux_sel) + 16'(40 * (7 - analog.trim));
   end
endmodule

// [tb/single_slope_adc_timer_tb.sv]
// Self-checking bench of the slope converter timer
`timescale 1ns/1ps
`include "ssa_defs.svh"
module single_slope_adc_timer_tb;
   import ssa_pkg::*;
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic         pwm_cycle_sync_pulse = 1'b0;
   logic [3:0]   comp_trip;
   logic [63:0]  trip_at = {16'h001E, 16'hF000, 16'h0028, 16'h0014};
   ssa_axi_req_t axi_req = '0;
   ssa_axi_rsp_t axi_rsp;
   ssa_analog_t  analog;
   int           num_errors = 0;
   int           n_tests = 0;
   logic [31:0]  rd;
   logic [31:0]  res [4];
   logic [1:0]   resp;
   logic [7:0]   mode;
   int           n;
   int           dv;
   bit           cal_done = 1'b0;
   // Max count of a 302-cycle window less 5 discharge cycles, times 2.5/3.5
   localparam int CAL_TARGET = 297 * 5 / 7;
   ssa_timer #(.CNT_W(12)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .pwm_cycle_sync_pulse(pwm_cycle_sync_pulse), .comp_trip(comp_trip), .analog(analog));
   ssa_comp_model comp (.aclk(aclk), .analog(analog), .trip_at(trip_at), .comp_trip(comp_trip));
   // 50 MHz clock
   always #10 aclk = ~aclk;
   // Verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw = 1;
      bit w = 1;
      @(posedge aclk);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && axi_rsp.awready) begin
            aw = 0;
            axi_req.awvalid <= 1'b0;
         end
         if (w && axi_rsp.wready) begin
            w = 0;
            axi_req.wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (axi_rsp.bvalid !== 1'b1);
      r = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
   endtask
   task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
      axi_req.arvalid <= 1'b0;
      do @(posedge aclk); while (axi_rsp.rvalid !== 1'b1);
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
   endtask
   // One-cycle sync pulse from the PWM unit
   task automatic pulse();
      @(posedge aclk);
      pwm_cycle_sync_pulse <= 1'b1;
      @(posedge aclk);
      pwm_cycle_sync_pulse <= 1'b0;
   endtask
   // Hang guard, about two and a half times the expected run of some 4000 cycles
   initial begin
      #200_000;
      num_errors++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values and access kinds
      rdr(`SSA_OFF_MODE, rd, resp);
      chk(rd, 32'h0000_0000);
      rdr(`SSA_OFF_WIDTH, rd, resp);
      chk(rd, 32'h0000_0064);
      rdr(`SSA_OFF_TRIM, rd, resp);
      chk(rd, 32'h0000_0000);
      wr(`SSA_OFF_TRIM, 32'hFFFF_FFFF, resp);
      chk({30'h0, resp}, 32'h0000_0000);
      rdr(`SSA_OFF_TRIM, rd, resp);
      chk(rd, 32'h0000_0007);
      chk({29'h0, analog.trim}, 32'h0000_0007);
      wr(12'h020, 32'h0000_0001, resp);
      chk({30'h0, resp}, 32'h0000_0002);
      rdr(12'h020, rd, resp);
      chk({rd[29:0], resp}, 32'h0000_0002);
      // Discharge length follows the width register, zero acts as one
      for (int i = 0; i < 3; i++) begin
         wr(`SSA_OFF_WIDTH, (i == 2) ? 32'h0000_0005 : 32'(i), resp);
         pulse();
         n = 0;
         repeat (200) begin
            @(posedge aclk);
            if (analog.discharge === 1'b1) n++;
         end
         chk(32'(n), (i == 2) ? 32'h0000_0005 : 32'h0000_0001);
      end
      // Four select codes at full rate, then the slow rate
      for (int i = 0; i < 5; i++) begin
         mode = (i < 4) ? {1'b1, 5'b0, 2'(i)} : 8'h03;
         dv = (i < 4) ? 1 : 2;
         wr(`SSA_OFF_MODE, {24'h0, mode}, resp);
         chk({30'h0, analog.aux_sel}, {30'h0, mode[1:0]});
         pulse();
         repeat (300) @(posedge aclk);
         pulse();
         for (int c = 0; c < 4; c++) begin
            rdr(`SSA_OFF_RES1 + 12'(4 * c), res[c], resp);
         end
         chk(res[1] - res[0], 32'(20 / dv));
         chk(res[2], 32'h0000_0FFF);
         chk(res[3] - res[0], 32'((10 + 10 * mode[1:0]) / dv));
      end
      // Results read again while the next window runs: RES1 recaptures the same count, RES3 still holds its overflow code
      repeat (200) @(posedge aclk);
      rdr(`SSA_OFF_RES1, rd, resp);
      chk(rd, res[0]);
      rdr(`SSA_OFF_RES3, rd, resp);
      chk(rd, 32'h0000_0FFF);
      chk({31'h0, analog.sync_active}, 32'h0000_0001);
      // Calibration: reference on aux, trim from zero, step up while above target
      wr(`SSA_OFF_MODE, 32'h0000_0083, resp);
      wr(`SSA_OFF_TRIM, 32'h0000_0000, resp);
      for (int t = 0; t < 8 && !cal_done; t++) begin
         pulse();
         repeat (300) @(posedge aclk);
         pulse();
         rdr(`SSA_OFF_RESAUX, rd, resp);
         chk(rd, (t < 2) ? 32'h0000_0FFF : 32'(340 - 40 * t));
         if (rd > CAL_TARGET) begin
            wr(`SSA_OFF_TRIM, 32'(t + 1), resp);
         end else begin
            cal_done = 1'b1;
         end
      end
      rdr(`SSA_OFF_TRIM, rd, resp);
      chk(rd, 32'h0000_0004);
      end_of_test();
   end
endmodule
